// ===== bench/link_remote_end.sv
// Behavioural far end of the serial links: credit replies and rx faults
`default_nettype none
module link_remote_end (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       slow,
    input  wire logic [7:0] token_in,
    input  wire logic [7:0] err_inject,
    output logic [7:0]      credit_out,
    output logic [7:0]      err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pipe [8];
    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            pipe[i] <= reset ? 8'h00 : {pipe[i][6:0], token_in[i]};
        end
        err_out <= reset ? 8'h00 : err_inject;
    end
    // Slow mode leaves room to see the credit cleared before it returns
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            credit_out[i] = slow ? pipe[i][7] : pipe[i][0];
        end
    end
endmodule // link_remote_end
`default_nettype wire

// ===== bench/serial_link_config_control_tb.sv
// Register-level testbench for the serial link register bank
`default_nettype none
module serial_link_config_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     core_clk;
    logic                     reset;
    logic                     bus_wr;
    logic                     bus_rd;
    logic                     slow;
    logic                     irq;
    logic [9:0]               bus_addr;
    logic [31:0]              bus_wdata;
    logic [31:0]              bus_rdata;
    logic [31:0]              d;
    logic [31:0]              w;
    logic [7:0]               rx_error_evt;
    logic [7:0]               credit_grant;
    logic [7:0]               credit_rx_evt;
    logic [7:0]               tok_send;
    logic [7:0]               rx_resync;
    logic [7:0]               tx_sym_valid;
    logic [7:0]               tx_sym_last;
    logic [7:0]               tx_sym_ready;
    logic [7:0]               route_bypass;
    logic [7:0]               err_inject;
    link_cfg_pkg::link_ctrl_s link_ctrl [8];
    link_cfg_pkg::dest_s      route_dest [8];
    link_cfg_pkg::dest_s      deliver_dest [8];
    int                       n_errors;
    int                       tests_run;
    int                       lmap [8] = '{2, 3, 0, 1, 6, 7, 4, 5};

    link_cfg_bank dut (.core_clk, .reset, .bus_addr, .bus_wdata, .bus_wr,
        .bus_rd, .bus_rdata, .link_ctrl, .rx_error_evt, .credit_grant,
        .credit_rx_evt, .credit_request_token_send(tok_send), .rx_resync,
        .tx_sym_valid, .tx_sym_last, .tx_sym_ready, .route_dest,
        .deliver_dest, .route_bypass, .irq);
    link_remote_end far (.core_clk, .reset, .slow, .token_in(tok_send),
        .err_inject, .credit_out(credit_rx_evt), .err_out(rx_error_evt));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [9:0] cfg(input int i);
        return 10'h200 + 10'(4 * i);
    endfunction

    function automatic logic [9:0] st(input int i);
        return 10'h280 + 10'(4 * i);
    endfunction

    task end_of_test;
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [9:0] a, input logic [31:0] v);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task rchk(input logic [9:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
        check(d, exp);
    endtask

    // Sample off the edge so a set in this step is seen
    task wait_irq;
        #1;
        for (int k = 0; k < 50 && irq !== 1'b1; k++)
            @(posedge core_clk) #1;
        if (irq !== 1'b1)
        begin
            n_errors++;
            end_of_test;
        end
    endtask

    // Valid held high: cycles from one send to the next on link 0
    task pace(input logic l, input int g);
        int c;
        @(posedge core_clk);
        tx_sym_last <= {7'h00, l};
        #1;
        for (c = 0; c < 100 && tx_sym_ready[0] !== 1'b1; c++)
            @(posedge core_clk) #1;
        if (tx_sym_ready[0] !== 1'b1)
        begin
            n_errors++;
            end_of_test;
        end
        c = 0;
        do
        begin
            @(posedge core_clk) #1;
            c++;
        end while (tx_sym_ready[0] !== 1'b1 && c < 100);
        check(32'(c), 32'(g + 2));
        if (c >= 100)
            end_of_test;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_of_test;
    end

    initial
    begin
        {reset, bus_wr, bus_rd, slow} = 4'h8;
        {bus_addr, bus_wdata} = '0;
        {credit_grant, tx_sym_valid, tx_sym_last, err_inject} = '0;
        for (int i = 0; i < 8; i++)
            route_dest[i] = {1'b1, 5'(i + 9)};
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rchk(cfg(i), 32'h0);
            rchk(st(i), 32'h0);
        end
        rchk(10'h300, 32'h0);
        rchk(10'h304, 32'h0);
        wr(10'h3FC, 32'hFFFF_FFFF);
        rchk(10'h3FC, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            w = 32'hBE40_0000 | (32'(i[0]) << 30) | (32'(i + 1) << 11);
            w = w | 32'(11'h7FF - 11'(i));
            wr(cfg(i), w);
            rchk(cfg(i), w & 32'hC03F_FFFF);
            check(32'(link_ctrl[i]), {8'h00, w[31:30], w[21:0]});
        end
        wr(cfg(1), 32'h0);
        wr(cfg(0), 32'h8000_1805);
        tx_sym_valid <= 8'hFF;
        pace(1'b0, 3);
        pace(1'b1, 5);
        check({31'h0, tx_sym_ready[1]}, 32'h0);
        @(posedge core_clk);
        tx_sym_valid <= 8'h00;
        for (int s = 0; s < 8; s++)
        begin
            w = s[0] ? 32'h7FFF_FEE0 : 32'hFFFF_FEE0;
            w = w | (32'(s[1]) << 8) | 32'(s + 3);
            wr(st(s), w);
            rchk(st(s), w & 32'h8000_011F);
        end
        check({24'h0, route_bypass}, 32'h55);
        for (int s = 0; s < 8; s++)
        begin
            w = s[0] ? 32'(route_dest[lmap[s]]) : {26'h0, s[1], 5'(s + 3)};
            check(32'(deliver_dest[lmap[s]]), w);
        end
        wr(10'h304, 32'h8);
        @(posedge core_clk);
        err_inject <= 8'h08;
        @(posedge core_clk);
        err_inject <= 8'h00;
        wait_irq;
        rchk(10'h300, 32'h8);
        wr(10'h304, 32'h0);
        #1;
        check({31'h0, irq}, 32'h0);
        wr(10'h300, 32'h8);
        wr(10'h304, 32'h8);
        #1;
        check({31'h0, irq}, 32'h0);
        rchk(cfg(3), 32'hC800_27FC);
        wr(cfg(3), 32'h0080_0000);
        #1;
        check({rx_resync, tok_send}, 16'h0800);
        rchk(cfg(3), 32'h0);
        wr(10'h304, 32'h100);
        wr(cfg(0), 32'h8100_0000);
        #1;
        check({24'h0, tok_send}, 32'h1);
        wait_irq;
        rchk(cfg(0), 32'h8200_0000);
        // Let the fast echo drain before the far end's delay grows
        repeat (10) @(posedge core_clk);
        slow <= 1'b1;
        wr(cfg(0), 32'h8100_0000);
        rchk(cfg(0), 32'h8000_0000);
        wr(10'h300, 32'h100);
        wait_irq;
        rchk(cfg(0), 32'h8200_0000);
        @(posedge core_clk);
        credit_grant <= 8'h01;
        rchk(cfg(0), 32'h8600_0000);
        wr(cfg(0), 32'h0);
        #1;
        check({31'h0, tx_sym_ready[0]}, 32'h0);
        end_of_test;
    end
endmodule // serial_link_config_control_tb
`default_nettype wire

// ===== design/link_cfg_bank.sv
// Per-link configuration, credit control, pacing and static forwarding
//
// Our own choice: the address-and-strobe port.
`default_nettype none
// Notes on behaviour
// RULE_01 - Top config bit enables link, steers pins
// RULE_02 - Wire-mode bit: zero two-wire, one five-wire
// RULE_03 - Error flag on overflow or illegal token
// RULE_04 - Status bit shows credit granted remotely
// RULE_05 - Status bit shows credit held locally
// RULE_06 - Credit-reset clears credit, sends request token
// RULE_07 - Receiver reset resynchronises token framing
// RULE_08 - Symbol gap at least field plus one
// RULE_09 - Token gap at least field plus one
// RULE_10 - Eight config registers, consecutive addresses
// RULE_11 - Static mode bypasses routing to destination
// RULE_12 - Static destination processor bit
// RULE_13 - Static destination channel end field
// RULE_14 - Static registers ordered C,D,A,B,G,H,E,F
// RULE_15 - Reserved and command bits read zero
module link_cfg_bank #(
    parameter int NUM_LINKS = link_cfg_pkg::NUM_LINKS
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire logic [link_cfg_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [31:0]             bus_wdata,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    output logic [31:0]                  bus_rdata,
    output link_cfg_pkg::link_ctrl_s     link_ctrl [NUM_LINKS],
    input  wire logic [NUM_LINKS-1:0]    rx_error_evt,
    input  wire logic [NUM_LINKS-1:0]    credit_grant,
    input  wire logic [NUM_LINKS-1:0]    credit_rx_evt,
    output logic [NUM_LINKS-1:0]         credit_request_token_send,
    output logic [NUM_LINKS-1:0]         rx_resync,
    input  wire logic [NUM_LINKS-1:0]    tx_sym_valid,
    input  wire logic [NUM_LINKS-1:0]    tx_sym_last,
    output logic [NUM_LINKS-1:0]         tx_sym_ready,
    input  wire link_cfg_pkg::dest_s     route_dest [NUM_LINKS],
    output link_cfg_pkg::dest_s          deliver_dest [NUM_LINKS],
    output logic [NUM_LINKS-1:0]         route_bypass,
    output logic                         irq
);
    localparam int GW = link_cfg_pkg::GAP_W;

    if (NUM_LINKS != 8)
    begin : g_bad_links
        $error("link_cfg_bank serves exactly eight links");
    end

    // Address decode
    logic [7:0] idx;
    logic       cfg_hit;
    logic       st_hit;
    logic       stat_hit;
    logic       mask_hit;
    logic [2:0] sel;
    assign idx      = bus_addr[link_cfg_pkg::ADDR_W-1:2];
    assign sel      = idx[2:0];
    assign cfg_hit  = idx[7:3] == link_cfg_pkg::CFG_BASE_IDX[7:3]; // RULE_10
    assign st_hit   = idx[7:3] == link_cfg_pkg::STATIC_BASE_IDX[7:3];
    assign stat_hit = idx == link_cfg_pkg::IRQ_STAT_IDX;
    assign mask_hit = idx == link_cfg_pkg::IRQ_MASK_IDX;

    link_cfg_pkg::link_ctrl_s ctrl_reg [NUM_LINKS];
    logic [NUM_LINKS-1:0] err_reg;
    logic [NUM_LINKS-1:0] hold_reg;
    logic [NUM_LINKS-1:0] creq_reg;
    logic [NUM_LINKS-1:0] resync_reg;
    logic [NUM_LINKS-1:0] st_en_reg;
    link_cfg_pkg::dest_s  st_dest_reg [NUM_LINKS];
    link_cfg_pkg::dest_s  dest_reg [NUM_LINKS];
    logic [GW:0]          gap_cnt_reg [NUM_LINKS];
    logic [15:0]          stat_reg;
    logic [15:0]          mask_reg;
    logic [31:0]          rdata_reg;
    logic [NUM_LINKS-1:0] hold_rise;
    logic [NUM_LINKS-1:0] tx_fire;

    for (genvar i = 0; i < NUM_LINKS; i++)
    begin : g_link
        logic cfg_wr;
        logic st_wr;
        logic crst;
        logic [GW:0] gap_next;
        assign cfg_wr = bus_wr && cfg_hit && sel == 3'(i);
        // RULE_14
        assign st_wr  = bus_wr && st_hit &&
            link_cfg_pkg::STATIC_LINK_MAP[sel] == 3'(i);
        assign crst   = cfg_wr && bus_wdata[link_cfg_pkg::CFG_CRST_BIT];
        assign tx_fire[i] = tx_sym_valid[i] && tx_sym_ready[i];
        // Pacing counter counts the idle cycles still owed
        assign gap_next = tx_sym_last[i]
            ? {1'b0, ctrl_reg[i].tok_gap} + (GW+1)'(1)  // RULE_09
            : {1'b0, ctrl_reg[i].sym_gap} + (GW+1)'(1); // RULE_08
        assign tx_sym_ready[i] = ctrl_reg[i].enable &&
            gap_cnt_reg[i] == '0;                       // RULE_08 RULE_09
        assign hold_rise[i] = credit_rx_evt[i] && !hold_reg[i];

        always_ff @(posedge core_clk)
        begin
            if (reset)
            begin
                ctrl_reg[i] <= '{1'b0, 1'b0,
                    link_cfg_pkg::GAP_RESET, link_cfg_pkg::GAP_RESET};
            end
            else if (cfg_wr)
            begin
                ctrl_reg[i].enable <=
                    bus_wdata[link_cfg_pkg::CFG_EN_BIT];  // RULE_01
                ctrl_reg[i].five_wire <=
                    bus_wdata[link_cfg_pkg::CFG_WIRE_BIT]; // RULE_02
                ctrl_reg[i].sym_gap <=
                    bus_wdata[link_cfg_pkg::CFG_SYM_LSB +: GW];
                ctrl_reg[i].tok_gap <=
                    bus_wdata[link_cfg_pkg::CFG_TOK_LSB +: GW];
            end
        end

        // Flags: hardware set wins over the clearing command
        always_ff @(posedge core_clk)
        begin
            if (reset)
            begin
                err_reg[i]    <= 1'b0;
                hold_reg[i]   <= 1'b0;
                creq_reg[i]   <= 1'b0;
                resync_reg[i] <= 1'b0;
            end
            else
            begin
                if (rx_error_evt[i])
                    err_reg[i] <= 1'b1;                   // RULE_03
                else if (resync_reg[i])
                    err_reg[i] <= 1'b0;
                if (credit_rx_evt[i])
                    hold_reg[i] <= 1'b1;                  // RULE_05
                else if (crst)
                    hold_reg[i] <= 1'b0;                  // RULE_06
                creq_reg[i]   <= crst;                    // RULE_06
                resync_reg[i] <= cfg_wr &&
                    bus_wdata[link_cfg_pkg::CFG_RXRST_BIT]; // RULE_07
            end
        end

        always_ff @(posedge core_clk)
        begin
            if (reset)
                gap_cnt_reg[i] <= '0;
            else if (tx_fire[i])
                gap_cnt_reg[i] <= gap_next;
            else if (gap_cnt_reg[i] != '0)
                gap_cnt_reg[i] <= gap_cnt_reg[i] - (GW+1)'(1);
        end

        always_ff @(posedge core_clk)
        begin
            if (reset)
            begin
                st_en_reg[i]   <= 1'b0;
                st_dest_reg[i] <= '{1'b0, link_cfg_pkg::CHAN_RESET};
            end
            else if (st_wr)
            begin
                st_en_reg[i] <= bus_wdata[link_cfg_pkg::ST_EN_BIT];
                st_dest_reg[i].proc <=
                    bus_wdata[link_cfg_pkg::ST_PROC_BIT];   // RULE_12
                st_dest_reg[i].chanend <= bus_wdata[
                    link_cfg_pkg::ST_CHAN_LSB +:
                    link_cfg_pkg::CHAN_W];                  // RULE_13
            end
        end

        // Static mode overrides whatever the router picked
        always_ff @(posedge core_clk)
        begin
            if (reset)
                dest_reg[i] <= '{1'b0, link_cfg_pkg::CHAN_RESET};
            else if (st_en_reg[i])
                dest_reg[i] <= st_dest_reg[i];              // RULE_11
            else
                dest_reg[i] <= route_dest[i];
        end

        assign link_ctrl[i]    = ctrl_reg[i];
        assign deliver_dest[i] = dest_reg[i];
    end

    assign route_bypass = st_en_reg;                        // RULE_11
    assign credit_request_token_send = creq_reg;
    assign rx_resync = resync_reg;

    // Interrupt status: errors low byte, credit arrival high byte
    logic [15:0] stat_set;
    logic [15:0] stat_clr;
    assign stat_set = {hold_rise, rx_error_evt};
    assign stat_clr = (bus_wr && stat_hit) ? bus_wdata[15:0] : 16'h0000;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stat_reg <= link_cfg_pkg::IRQ_RESET;
            mask_reg <= link_cfg_pkg::IRQ_RESET;
        end
        else
        begin
            stat_reg <= (stat_reg & ~stat_clr) | stat_set;
            if (bus_wr && mask_hit)
                mask_reg <= bus_wdata[15:0];
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // Read path; command and reserved bits are zero
    logic [31:0] cfg_word;
    logic [31:0] st_word;
    logic [31:0] rd_mux;
    link_cfg_pkg::link_ctrl_s rc;
    link_cfg_pkg::dest_s      rs;
    logic [2:0] st_link;
    assign rc = ctrl_reg[sel];
    assign st_link = link_cfg_pkg::STATIC_LINK_MAP[sel];    // RULE_14
    assign rs = st_dest_reg[st_link];
    assign cfg_word = {rc.enable, rc.five_wire, 2'b00, err_reg[sel],
        credit_grant[sel], hold_reg[sel], 3'b000,           // RULE_04
        rc.sym_gap, rc.tok_gap};                            // RULE_15
    assign st_word = {st_en_reg[st_link], 22'h000000, rs.proc,
        3'b000, rs.chanend};                                // RULE_15
    assign rd_mux = cfg_hit  ? cfg_word :
                    st_hit   ? st_word :
                    stat_hit ? {16'h0000, stat_reg} :
                    mask_hit ? {16'h0000, mask_reg} : 32'h00000000;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            rdata_reg <= 32'h00000000;
        else if (bus_rd)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 32'h00000000;
    end

    assign bus_rdata = rdata_reg;

    // Checks on link 0, its static slot, link 3 for errors and resync, link 1 when disabled, and link 7 config
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    logic wr0;
    assign wr0 = bus_wr && cfg_hit && sel == 3'h0;

    property p_enable;
        wr0 |=> link_ctrl[0].enable == $past(bus_wdata[31]);
    endproperty
    a_enable: assert property (p_enable) // RULE_01
        else $error("link enable did not follow write");

    property p_wire;
        wr0 |=> link_ctrl[0].five_wire == $past(bus_wdata[30]);
    endproperty
    a_wire: assert property (p_wire) // RULE_02
        else $error("wire mode did not follow write");

    property p_err;
        rx_error_evt[3] |=> err_reg[3] [*2];
    endproperty
    a_err: assert property (p_err) // RULE_03
        else $error("error flag lost");

    sequence s_read0;
        bus_rd && cfg_hit && sel == 3'h0;
    endsequence
    property p_grant;
        s_read0 |=> bus_rdata[26] == $past(credit_grant[0]) &&
            bus_rdata[25] == $past(hold_reg[0]);
    endproperty
    a_grant: assert property (p_grant) // RULE_04
        else $error("credit status readback wrong");

    property p_hold;
        credit_rx_evt[0] |=> hold_reg[0];
    endproperty
    a_hold: assert property (p_hold) // RULE_05
        else $error("credit not held after arrival");

    property p_crst;
        wr0 && bus_wdata[24] && !credit_rx_evt[0] |=>
            credit_request_token_send[0] && !hold_reg[0] ##1
            !credit_request_token_send[0];
    endproperty
    a_crst: assert property (p_crst) // RULE_06
        else $error("credit reset misbehaved");

    property p_resync;
        bus_wr && cfg_hit && sel == 3'h3 && bus_wdata[23] |=>
            rx_resync[3] ##1 !rx_resync[3];
    endproperty
    a_resync: assert property (p_resync) // RULE_07
        else $error("receiver resync pulse wrong");

    property p_sym_gap;
        tx_fire[0] && !tx_sym_last[0] |=>
            gap_cnt_reg[0] == {1'b0, $past(ctrl_reg[0].sym_gap)} + 1;
    endproperty
    a_sym_gap: assert property (p_sym_gap) // RULE_08
        else $error("symbol gap count wrong");

    property p_tok_gap;
        tx_fire[0] && tx_sym_last[0] |=>
            gap_cnt_reg[0] == {1'b0, $past(ctrl_reg[0].tok_gap)} + 1;
    endproperty
    a_tok_gap: assert property (p_tok_gap) // RULE_09
        else $error("token gap count wrong");

    property p_idle;
        gap_cnt_reg[0] != '0 |-> !tx_sym_ready[0];
    endproperty
    a_idle: assert property (p_idle) // RULE_08
        else $error("ready during idle gap");

    property p_static_map;
        bus_wr && st_hit && sel == 3'h2 |=>
            route_bypass[0] == $past(bus_wdata[31]);
    endproperty
    a_static_map: assert property (p_static_map) // RULE_14
        else $error("static slot two does not steer link A");

    property p_static_dest;
        route_bypass[0] |=> deliver_dest[0] == $past(st_dest_reg[0]);
    endproperty
    a_static_dest: assert property (p_static_dest) // RULE_11
        else $error("static traffic not sent to fixed destination");

    property p_reserved;
        s_read0 |=> bus_rdata[29:28] == 2'h0 && bus_rdata[24:22] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) // RULE_15
        else $error("reserved or command bits read nonzero");

    property p_err_clear;
        rx_resync[3] && !rx_error_evt[3] |=> !err_reg[3];
    endproperty
    a_err_clear: assert property (p_err_clear) // RULE_07
        else $error("error flag survived receiver reset");

    property p_cfg_last;
        bus_wr && cfg_hit && sel == 3'h7 |=>
            link_ctrl[7].tok_gap == $past(bus_wdata[10:0]);
    endproperty
    a_cfg_last: assert property (p_cfg_last) // RULE_10
        else $error("last config register does not reach link 7");

    property p_static_proc;
        bus_wr && st_hit && sel == 3'h2 |=>
            st_dest_reg[0].proc == $past(bus_wdata[8]);
    endproperty
    a_static_proc: assert property (p_static_proc) // RULE_12
        else $error("static processor select not stored");

    property p_static_chan;
        bus_wr && st_hit && sel == 3'h2 |=>
            st_dest_reg[0].chanend == $past(bus_wdata[4:0]);
    endproperty
    a_static_chan: assert property (p_static_chan) // RULE_13
        else $error("static channel end not stored");

    property p_static_rsvd;
        bus_rd && st_hit |=>
            bus_rdata[30:9] == 22'h000000 && bus_rdata[7:5] == 3'h0;
    endproperty
    a_static_rsvd: assert property (p_static_rsvd) // RULE_15
        else $error("static reserved bits read nonzero");

    property p_disabled;
        !link_ctrl[1].enable |-> !tx_sym_ready[1];
    endproperty
    a_disabled: assert property (p_disabled) // RULE_01
        else $error("disabled link offered to send");

endmodule // link_cfg_bank
`default_nettype wire

// ===== design/link_cfg_pkg.sv
// Constants and carrier types for the serial link register bank
`default_nettype none
package link_cfg_pkg;
    localparam int NUM_LINKS = 8;
    localparam int GAP_W     = 11;
    localparam int CHAN_W    = 5;
    localparam int ADDR_W    = 10;
    // Register indices; byte address is four times the index
    localparam logic [7:0] CFG_BASE_IDX    = 8'h80;
    localparam logic [7:0] STATIC_BASE_IDX = 8'hA0;
    localparam logic [7:0] IRQ_STAT_IDX    = 8'hC0;
    localparam logic [7:0] IRQ_MASK_IDX    = 8'hC1;
    // Link configuration fields
    localparam int CFG_EN_BIT   = 31;
    localparam int CFG_WIRE_BIT = 30;
    localparam int CFG_ERR_BIT  = 27;
    localparam int CFG_GRANT_BIT = 26;
    localparam int CFG_HOLD_BIT = 25;
    localparam int CFG_CRST_BIT = 24;
    localparam int CFG_RXRST_BIT = 23;
    localparam int CFG_SYM_LSB  = 11;
    localparam int CFG_TOK_LSB  = 0;
    // Static forwarding fields
    localparam int ST_EN_BIT    = 31;
    localparam int ST_PROC_BIT  = 8;
    localparam int ST_CHAN_LSB  = 0;
    // Reset values
    localparam logic [GAP_W-1:0] GAP_RESET = 11'h000;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;
    localparam logic [15:0] IRQ_RESET = 16'h0000;
    // Static register order C,D,A,B,G,H,E,F as link numbers
    localparam logic [2:0] STATIC_LINK_MAP [NUM_LINKS] =
        '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};

    typedef struct packed {
        logic             enable;
        logic             five_wire;
        logic [GAP_W-1:0] sym_gap;
        logic [GAP_W-1:0] tok_gap;
    } link_ctrl_s;

    typedef struct packed {
        logic              proc;
        logic [CHAN_W-1:0] chanend;
    } dest_s;
endpackage
`default_nettype wire
